// ### rtl/bbj_exec.sv
/*
 Execution of conditional, segment and bit-test jumps plus word move.
 Assumes one decoded instruction per i_valid pulse, its address on i_insn_ip,
 the tested bit value and source words already fetched by the decode path.
*/
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// - bit-modify jumps clear E, V, C; N gets old bit, Z its inverse.
// - opcode AA is jump-if-set-and-clear, four bytes, bit address and displacement.
// - absolute jump loads IP with 16-bit offset if condition holds, else next.
// - absolute jump prediction bit 0 means taken, 1 means not taken.
// - indirect jump loads IP from chosen word register when condition holds.
// - relative jump adds twice sign-extended displacement to next address.
// - inter-segment jump always loads IP; segment only when disable bit is 0.
// - jump-if-bit-clear branches by twice displacement when bit is 0.
// - jump-if-clear-and-set writes 1 to clear bit and branches.
// - bit-modify jumps update flags always; explicit status write wins.
// - word move copies 16-bit source to destination and sets flags.
module bbj_exec (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_valid,
   input wire bbj_pkg::bbj_insn_t i_insn,
   input wire logic [15:0] i_insn_ip,
   input wire logic i_bit_value,
   input wire logic [15:0] i_reg_word,
   input wire logic i_segmentation_disable,
   input wire logic i_psw_write,
   input wire logic [4:0] i_psw_data,
   output logic [15:0] o_instruction_pointer,
   output logic [7:0] o_code_segment_pointer,
   output bbj_pkg::bbj_flags_t o_flags,
   output logic o_branch_taken,
   output logic o_predict_taken,
   output logic o_prefetch_hint,
   output logic o_bit_write,
   output logic o_bit_write_value,
   output logic o_move_write,
   output logic [15:0] o_move_data,
   output logic o_unknown_opcode
);
   logic [15:0] ip_reg;
   logic [15:0] ip_next;
   logic [7:0] cseg_reg;
   logic [7:0] cseg_next;
   bbj_pkg::bbj_flags_t flags_reg;
   bbj_pkg::bbj_flags_t flags_next;
   logic taken_reg;
   logic predict_reg;
   logic hint_reg;
   logic bitw_reg;
   logic bitv_reg;
   logic movw_reg;
   logic [15:0] movd_reg;
   logic unk_reg;
   logic taken_next;
   logic bitw_next;
   logic bitv_next;
   logic movw_next;
   logic unk_next;

   wire logic [7:0] opc = i_insn.opcode;
   wire logic is_bsc = opc == bbj_pkg::OPC_JUMP_BIT_SET_CLEAR;
   wire logic is_bcs = opc == bbj_pkg::OPC_JUMP_BIT_CLEAR_SET;
   wire logic is_bs = opc == bbj_pkg::OPC_JUMP_BIT_SET;
   wire logic is_bc = opc == bbj_pkg::OPC_JUMP_BIT_CLEAR;
   wire logic is_abs = opc == bbj_pkg::OPC_JUMP_ABSOLUTE;
   wire logic is_ind = opc == bbj_pkg::OPC_JUMP_INDIRECT_COND;
   wire logic is_seg = opc == bbj_pkg::OPC_JUMP_INTER_SEGMENT;
   wire logic is_rel = opc[3:0] == bbj_pkg::OPC_JUMP_RELATIVE_LOW;
   wire logic is_movr = opc == bbj_pkg::OPC_WORD_MOVE_REG;
   wire logic is_movi = opc == bbj_pkg::OPC_WORD_MOVE_IMM;
   wire logic is_long = is_bsc | is_bcs | is_bs | is_bc | is_abs | is_seg | is_movi;
   wire logic [15:0] seq_ip = i_insn_ip + (is_long ? bbj_pkg::LEN_LONG : bbj_pkg::LEN_SHORT);
   // relative displacement is byte 1 for short form, byte 2 for bit jumps
   wire logic [7:0] disp = (is_rel & ~is_bsc & ~is_bcs) ? i_insn.byte1 : i_insn.byte2;
   wire logic [15:0] rel_target = seq_ip + {{7{disp[7]}}, disp, 1'b0};
   wire logic [15:0] long_operand = {i_insn.byte3, i_insn.byte2};
   // short relative form has its byte 1 taken by the displacement, so its condition rides in the opcode
   wire logic [3:0] cc_code = is_rel ? opc[7:4] : i_insn.byte1[7:4];
   logic cond_met;

   bbj_cond_eval u_cond (
      .i_code(cc_code),
      .i_flags(flags_reg),
      .o_met(cond_met)
   );

   wire logic rel_only = is_rel & ~is_bsc & ~is_bcs & ~is_movi;
   wire logic bit_modify = is_bsc | is_bcs;
   wire logic bit_branch = (is_bsc & i_bit_value) | (is_bcs & ~i_bit_value)
      | (is_bs & i_bit_value) | (is_bc & ~i_bit_value);
   wire logic [15:0] move_src = is_movi ? long_operand : i_reg_word;
   bbj_pkg::bbj_flags_t bit_flags;
   bbj_pkg::bbj_flags_t move_flags;

   always_comb
   begin
      bit_flags = flags_reg;
      bit_flags.e = 1'b0;
      bit_flags.v = 1'b0;
      bit_flags.c = 1'b0;
      bit_flags.n = i_bit_value;
      bit_flags.z = ~i_bit_value;
      move_flags = flags_reg;
      move_flags.e = move_src == 16'h8000;
      move_flags.z = move_src == 16'h0000;
      move_flags.n = move_src[15];
   end

   always_comb
   begin
      ip_next = ip_reg;
      cseg_next = cseg_reg;
      flags_next = flags_reg;
      taken_next = 1'b0;
      bitw_next = 1'b0;
      bitv_next = 1'b0;
      movw_next = 1'b0;
      unk_next = 1'b0;
      if (i_valid)
      begin
         ip_next = seq_ip;
         if (bit_modify | is_bs | is_bc)
         begin
            if (bit_branch)
            begin
               ip_next = rel_target;
               taken_next = 1'b1;
            end
            if (bit_modify)
            begin
               flags_next = bit_flags;
               bitw_next = bit_branch;
               bitv_next = is_bcs;
            end
         end
         else if (is_abs)
         begin
            if (cond_met)
            begin
               ip_next = long_operand;
               taken_next = 1'b1;
            end
         end
         else if (is_ind)
         begin
            if (cond_met)
            begin
               ip_next = i_reg_word;
               taken_next = 1'b1;
            end
         end
         else if (is_seg)
         begin
            ip_next = long_operand;
            taken_next = 1'b1;
            if (!i_segmentation_disable)
            begin
               cseg_next = i_insn.byte1;
            end
         end
         else if (is_movr | is_movi)
         begin
            flags_next = move_flags;
            movw_next = 1'b1;
         end
         else if (rel_only)
         begin
            if (cond_met)
            begin
               ip_next = rel_target;
               taken_next = 1'b1;
            end
         end
         else
         begin
            unk_next = 1'b1;
         end
      end
      if (i_psw_write)
      begin
         // explicit status write overrides implicit flag results
         flags_next = bbj_pkg::bbj_flags_t'(i_psw_data);
      end
   end

   always_ff @(posedge i_clock)
   begin
      if (!i_resetn)
      begin
         ip_reg <= bbj_pkg::IP_RESET;
         cseg_reg <= bbj_pkg::CODE_SEG_RESET;
         flags_reg <= bbj_pkg::bbj_flags_t'(bbj_pkg::FLAGS_RESET);
         taken_reg <= 1'b0;
         predict_reg <= 1'b0;
         hint_reg <= 1'b0;
         bitw_reg <= 1'b0;
         bitv_reg <= 1'b0;
         movw_reg <= 1'b0;
         movd_reg <= 16'h0000;
         unk_reg <= 1'b0;
      end
      else
      begin
         ip_reg <= ip_next;
         cseg_reg <= cseg_next;
         flags_reg <= flags_next;
         taken_reg <= taken_next;
         predict_reg <= i_valid & is_abs & ~i_insn.byte1[bbj_pkg::PREDICT_BIT];
         // hint is trusted from code generator, only forwarded to fetch
         hint_reg <= i_valid & is_abs & i_insn.byte1[bbj_pkg::HINT_BIT];
         bitw_reg <= bitw_next;
         bitv_reg <= bitv_next;
         movw_reg <= movw_next;
         movd_reg <= movw_next ? move_src : movd_reg;
         unk_reg <= unk_next;
      end
   end

   assign o_instruction_pointer = ip_reg;
   assign o_code_segment_pointer = cseg_reg;
   assign o_flags = flags_reg;
   assign o_branch_taken = taken_reg;
   assign o_predict_taken = predict_reg;
   assign o_prefetch_hint = hint_reg;
   assign o_bit_write = bitw_reg;
   assign o_bit_write_value = bitv_reg;
   assign o_move_write = movw_reg;
   assign o_move_data = movd_reg;
   assign o_unknown_opcode = unk_reg;
endmodule : bbj_exec
`default_nettype wire

// ### pkg/bbj_pkg.sv
/*
 Constants and carrier types for the jump and word move execution block.
 Assumes a 16-bit byte-addressed code space and 4-bit condition codes.
*/
package bbj_pkg;
   localparam logic [7:0] OPC_JUMP_BIT_SET_CLEAR = 8'hAA;
   localparam logic [7:0] OPC_JUMP_BIT_CLEAR_SET = 8'hBA;
   localparam logic [7:0] OPC_JUMP_BIT_SET = 8'h8A;
   localparam logic [7:0] OPC_JUMP_BIT_CLEAR = 8'h9A;
   localparam logic [7:0] OPC_JUMP_ABSOLUTE = 8'hEA;
   localparam logic [7:0] OPC_JUMP_INDIRECT_COND = 8'h9C;
   localparam logic [7:0] OPC_JUMP_INTER_SEGMENT = 8'hFA;
   localparam logic [7:0] OPC_WORD_MOVE_REG = 8'hF0;
   localparam logic [7:0] OPC_WORD_MOVE_IMM = 8'hE6;
   localparam logic [3:0] OPC_JUMP_RELATIVE_LOW = 4'hD;
   localparam logic [15:0] IP_RESET = 16'h0000;
   localparam logic [7:0] CODE_SEG_RESET = 8'h00;
   localparam logic [4:0] FLAGS_RESET = 5'h00;
   localparam int FLAG_N = 0;
   localparam int FLAG_C = 1;
   localparam int FLAG_V = 2;
   localparam int FLAG_Z = 3;
   localparam int FLAG_E = 4;
   localparam int PREDICT_BIT = 0;
   localparam int HINT_BIT = 1;
   localparam logic [15:0] LEN_SHORT = 16'h0002;
   localparam logic [15:0] LEN_LONG = 16'h0004;

   typedef struct packed {
      logic [7:0] opcode;
      logic [7:0] byte1;
      logic [7:0] byte2;
      logic [7:0] byte3;
   } bbj_insn_t;

   typedef struct packed {
      logic e;
      logic z;
      logic v;
      logic c;
      logic n;
   } bbj_flags_t;
endpackage : bbj_pkg

// ### rtl/bbj_cond_eval.sv
/*
 Condition code evaluator for the jump execution block.
 Assumes the flags input is the current program status; purely combinational.
*/
`timescale 1ns/100ps
`default_nettype none
module bbj_cond_eval (
   input wire logic [3:0] i_code,
   input wire bbj_pkg::bbj_flags_t i_flags,
   output logic o_met
);
   // code map is a plain local choice; extended codes reuse the same table
   wire logic eq = i_flags.z;
   wire logic lt = i_flags.n ^ i_flags.v;
   always_comb
   begin
      case (i_code)
         4'h0: o_met = 1'b1;
         4'h1: o_met = ~i_flags.z;
         4'h2: o_met = eq;
         4'h3: o_met = ~i_flags.v;
         4'h4: o_met = i_flags.v;
         4'h5: o_met = ~i_flags.n;
         4'h6: o_met = i_flags.n;
         4'h7: o_met = ~i_flags.c;
         4'h8: o_met = i_flags.c;
         4'h9: o_met = ~i_flags.c & ~i_flags.z;
         4'hA: o_met = i_flags.c | i_flags.z;
         4'hB: o_met = ~lt & ~i_flags.z;
         4'hC: o_met = lt | i_flags.z;
         4'hD: o_met = ~lt;
         4'hE: o_met = lt;
         4'hF: o_met = i_flags.e;
         default: o_met = 1'b0;
      endcase
   end
endmodule : bbj_cond_eval
`default_nettype wire

// ### sim/bbj_fetch_model.sv
/*
 Fetch unit model handing one decoded instruction word to the jump block.
 Assumes the bench pulses i_load for one cycle per instruction.
*/
`timescale 1ns/100ps
`default_nettype none
module bbj_fetch_model (
   input wire logic i_load,
   input wire bbj_pkg::bbj_insn_t i_word,
   input wire logic [15:0] i_ip,
   output logic o_valid,
   output bbj_pkg::bbj_insn_t o_insn,
   output logic [15:0] o_insn_ip
);
   wire [15:0] back = i_ip - {i_word.byte3, i_word.byte2};
   wire is_abs = i_word.opcode == 8'hEA;
   wire hint = back != 16'h0000 && back <= 16'h0020;
   bbj_pkg::bbj_insn_t fixed;
   always_comb
   begin
      fixed = i_word;
      fixed.byte1[1] = is_abs ? hint : i_word.byte1[1];
   end
   // idle bus shows inverted code so a stale word never looks valid
   assign o_insn = i_load ? fixed : ~fixed;
   assign o_valid = i_load;
   assign o_insn_ip = i_ip;
endmodule : bbj_fetch_model
`default_nettype wire

// ### sim/bbj_exec_monitor.sv
/*
 Port checker for the jump execution block.
 Assumes one clock and the synchronous active-low reset of the block.
*/
`timescale 1ns/100ps
`default_nettype none
module bbj_exec_monitor (
   input wire logic i_clock,
   input wire logic i_resetn,
   input wire logic i_valid,
   input wire bbj_pkg::bbj_insn_t i_insn,
   input wire logic [15:0] i_insn_ip,
   input wire logic i_bit_value,
   input wire logic [15:0] i_reg_word,
   input wire logic i_segmentation_disable,
   input wire logic i_psw_write,
   input wire logic [4:0] i_psw_data,
   input wire logic [15:0] o_instruction_pointer,
   input wire logic [7:0] o_code_segment_pointer,
   input wire bbj_pkg::bbj_flags_t o_flags,
   input wire logic o_branch_taken,
   input wire logic o_predict_taken,
   input wire logic o_prefetch_hint,
   input wire logic o_bit_write,
   input wire logic o_bit_write_value,
   input wire logic o_move_write,
   input wire logic [15:0] o_move_data,
   input wire logic o_unknown_opcode
);
   wire [7:0] op = i_insn.opcode;
   wire [7:0] seg = i_insn.byte1;
   wire [15:0] lng = {i_insn.byte3, i_insn.byte2};
   wire [15:0] bt = i_insn_ip + 16'h0004 + {{7{i_insn.byte2[7]}}, i_insn.byte2, 1'h0};
   wire [15:0] rt = i_insn_ip + 16'h0002 + {{7{i_insn.byte1[7]}}, i_insn.byte1, 1'h0};
   wire al = i_insn.byte1[7:4] == 4'h0;
   wire pa = i_insn.byte1[0];
   wire bmod = op == 8'hAA || op == 8'hBA;
   default clocking cb @(posedge i_clock); endclocking
   default disable iff (!i_resetn);
   chk_bit_flags: assert property (i_valid && bmod && !i_psw_write |=>
      o_flags == {1'h0, !$past(i_bit_value), 2'h0, $past(i_bit_value)}) else $error("bit jump flags wrong");
   chk_set_clear: assert property (i_valid && op == 8'hAA && i_bit_value |=>
      o_bit_write && !o_bit_write_value && o_instruction_pointer == $past(bt)) else $error("set-clear jump wrong");
   chk_abs_target: assert property (i_valid && op == 8'hEA && al |=>
      o_branch_taken && o_instruction_pointer == $past(lng)) else $error("absolute jump wrong");
   chk_predict_bit: assert property (i_valid && op == 8'hEA |=> o_predict_taken == !$past(pa))
      else $error("prediction wrong");
   chk_indirect: assert property (i_valid && op == 8'h9C && al |=> o_instruction_pointer == $past(i_reg_word))
      else $error("indirect jump wrong");
   chk_relative: assert property (i_valid && op == 8'h0D |=> o_instruction_pointer == $past(rt))
      else $error("relative jump wrong");
   chk_segment_load: assert property (i_valid && op == 8'hFA |=> o_instruction_pointer == $past(lng) &&
      o_code_segment_pointer == ($past(i_segmentation_disable) ? $past(o_code_segment_pointer) : $past(seg)))
      else $error("segment jump wrong");
   chk_bit_clear: assert property (i_valid && op == 8'h9A && !i_bit_value |=>
      o_branch_taken && o_instruction_pointer == $past(bt)) else $error("bit clear jump wrong");
   chk_clear_set: assert property (i_valid && op == 8'hBA && !i_bit_value |=>
      o_bit_write && o_bit_write_value && o_instruction_pointer == $past(bt)) else $error("clear-set jump wrong");
   chk_psw_wins: assert property (i_valid && i_psw_write |=> o_flags == $past(i_psw_data))
      else $error("status write lost");
   chk_word_move: assert property (i_valid && op == 8'hF0 |=>
      o_move_write && o_move_data == $past(i_reg_word)) else $error("word move wrong");
endmodule : bbj_exec_monitor
bind bbj_exec bbj_exec_monitor i_mon (.i_clock(i_clock), .i_resetn(i_resetn), .i_valid(i_valid), .i_insn(i_insn),
   .i_insn_ip(i_insn_ip), .i_bit_value(i_bit_value), .i_reg_word(i_reg_word),
   .i_segmentation_disable(i_segmentation_disable), .i_psw_write(i_psw_write), .i_psw_data(i_psw_data),
   .o_instruction_pointer(o_instruction_pointer), .o_code_segment_pointer(o_code_segment_pointer),
   .o_flags(o_flags), .o_branch_taken(o_branch_taken), .o_predict_taken(o_predict_taken),
   .o_prefetch_hint(o_prefetch_hint), .o_bit_write(o_bit_write), .o_bit_write_value(o_bit_write_value),
   .o_move_write(o_move_write), .o_move_data(o_move_data), .o_unknown_opcode(o_unknown_opcode));
`default_nettype wire

// ### sim/branch_bit_jump_exec_tb.sv
/*
 Self-checking bench for the jump execution block, table driven.
 Assumes the fetch model and the bound port checker are compiled first.
*/
`timescale 1ns/100ps
`default_nettype none
module branch_bit_jump_exec_tb;
   typedef struct packed {
      logic [31:0] insn;
      logic [15:0] ip;
      logic bv;
      logic [15:0] rw;
      logic sd;
      logic [15:0] e_ip;
      logic [7:0] e_cseg;
      logic [4:0] e_fl;
      logic [6:0] e_pl;
   } bbj_row_t;
   // pulses: taken, predict, hint, bit write, bit value, move, unknown
   bbj_row_t rows [17] = '{
      '{32'hAA000200, 16'h0100, 1'h1, 16'h0000, 1'h0, 16'h0108, 8'h00, 5'h01, 7'h48},
      '{32'hAA000200, 16'h0100, 1'h0, 16'h0000, 1'h0, 16'h0104, 8'h00, 5'h08, 7'h00},
      '{32'hBA00FE00, 16'h0200, 1'h0, 16'h0000, 1'h0, 16'h0200, 8'h00, 5'h08, 7'h4C},
      '{32'hBA00FE00, 16'h0200, 1'h1, 16'h0000, 1'h0, 16'h0204, 8'h00, 5'h01, 7'h04},
      '{32'h9A008000, 16'h1000, 1'h0, 16'h0000, 1'h0, 16'h0F04, 8'h00, 5'h01, 7'h40},
      '{32'hEA005634, 16'h3470, 1'h0, 16'h0000, 1'h0, 16'h3456, 8'h00, 5'h01, 7'h70},
      '{32'hEAF15634, 16'h0300, 1'h0, 16'h0000, 1'h0, 16'h0304, 8'h00, 5'h01, 7'h00},
      '{32'h9C010000, 16'h0500, 1'h0, 16'h1234, 1'h0, 16'h1234, 8'h00, 5'h01, 7'h40},
      '{32'h0D7F0000, 16'h0400, 1'h0, 16'h0000, 1'h0, 16'h0500, 8'h00, 5'h01, 7'h40},
      '{32'hFA5A5634, 16'h0700, 1'h0, 16'h0000, 1'h0, 16'h3456, 8'h5A, 5'h01, 7'h40},
      '{32'hFAA55634, 16'h0700, 1'h0, 16'h0000, 1'h1, 16'h3456, 8'h5A, 5'h01, 7'h40},
      '{32'h8A000300, 16'h0A00, 1'h1, 16'h0000, 1'h0, 16'h0A0A, 8'h5A, 5'h01, 7'h40},
      '{32'h2D050000, 16'h0C00, 1'h0, 16'h0000, 1'h0, 16'h0C02, 8'h5A, 5'h01, 7'h00},
      '{32'h6DFF0000, 16'h0C00, 1'h0, 16'h0000, 1'h0, 16'h0C00, 8'h5A, 5'h01, 7'h40},
      '{32'hE6010000, 16'h0B00, 1'h0, 16'h0000, 1'h0, 16'h0B04, 8'h5A, 5'h08, 7'h02},
      '{32'hF0010000, 16'h0800, 1'h0, 16'h8000, 1'h0, 16'h0802, 8'h5A, 5'h11, 7'h02},
      '{32'h55000000, 16'h0900, 1'h0, 16'h0000, 1'h0, 16'h0902, 8'h5A, 5'h11, 7'h01}};
   logic clk;
   logic rstn = 1'h0;
   logic ld = 1'h0;
   logic [31:0] wd = 32'h00000000;
   logic [15:0] ip = 16'h0000;
   logic bv = 1'h0;
   logic [15:0] rw = 16'h0000;
   logic sd = 1'h0;
   logic pw = 1'h0;
   logic [4:0] pd = 5'h00;
   int fails = 0;
   int num_checks = 0;
   wire vld;
   wire [15:0] fip;
   wire [15:0] cur_ip;
   wire [15:0] md;
   wire [7:0] cur_cseg;
   wire [6:0] pl;
   bbj_pkg::bbj_insn_t fin;
   bbj_pkg::bbj_flags_t cur_fl;
   bbj_fetch_model i_fetch (.i_load(ld), .i_word(wd), .i_ip(ip), .o_valid(vld), .o_insn(fin), .o_insn_ip(fip));
   bbj_exec i_dut (.i_clock(clk), .i_resetn(rstn), .i_valid(vld), .i_insn(fin), .i_insn_ip(fip), .i_bit_value(bv),
      .i_reg_word(rw), .i_segmentation_disable(sd), .i_psw_write(pw), .i_psw_data(pd),
      .o_instruction_pointer(cur_ip), .o_code_segment_pointer(cur_cseg), .o_flags(cur_fl), .o_branch_taken(pl[6]),
      .o_predict_taken(pl[5]), .o_prefetch_hint(pl[4]), .o_bit_write(pl[3]), .o_bit_write_value(pl[2]),
      .o_move_write(pl[1]), .o_move_data(md), .o_unknown_opcode(pl[0]));
   initial
   begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
      num_checks++;
      if (got !== exp)
      begin
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
         fails++;
      end
   endtask : chk
   task automatic run(input bbj_row_t r);
      @(posedge clk);
      ld <= 1'h1;
      wd <= r.insn;
      ip <= r.ip;
      bv <= r.bv;
      rw <= r.rw;
      sd <= r.sd;
      @(posedge clk);
      ld <= 1'h0;
      #1;
   endtask : run
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : give_verdict
   initial
   begin
      repeat (20) @(posedge clk);
      rstn <= 1'h1;
      #1;
      chk("reset ip", 16'h0000, cur_ip);
      chk("reset flags", 16'h0000, {11'h000, cur_fl});
      chk("reset pulses", 16'h0000, {9'h000, pl});
      for (int k = 0; k < 17; k++)
      begin
         run(rows[k]);
         chk("ip", rows[k].e_ip, cur_ip);
         chk("code segment", {8'h00, rows[k].e_cseg}, {8'h00, cur_cseg});
         chk("flags", {11'h000, rows[k].e_fl}, {11'h000, cur_fl});
         chk("pulses", {9'h000, rows[k].e_pl}, {9'h000, pl});
      end
      chk("move data", 16'h8000, md);
      // explicit status write lands with a bit jump that would set other flags
      pw <= 1'h1;
      pd <= 5'h16;
      run(rows[0]);
      pw <= 1'h0;
      chk("psw wins", 16'h0016, {11'h000, cur_fl});
      @(posedge clk);
      rstn <= 1'h0;
      repeat (2) @(posedge clk);
      rstn <= 1'h1;
      #1;
      chk("rerun ip", 16'h0000, cur_ip);
      chk("rerun code segment", 16'h0000, {8'h00, cur_cseg});
      chk("rerun flags", 16'h0000, {11'h000, cur_fl});
      chk("rerun pulses", 16'h0000, {9'h000, pl});
      give_verdict();
   end
   initial
   begin
      #5000;
      fails++;
      give_verdict();
   end
endmodule : branch_bit_jump_exec_tb
`default_nettype wire
